// ### rtl/sar_adc_defines.vh
/*
 * Constants for the converter control block: register byte addresses,
 * field positions, reset values, start-mode codes and timing counts.
 * Assumes it is included by bare name from the rtl/ directory.
 */
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// register byte addresses (word aligned)
`define ADDR_CONTROL      8'h00
`define ADDR_CONFIG       8'h04
`define ADDR_RESULT_HIGH  8'h08
`define ADDR_RESULT_LOW   8'h0C
`define ADDR_TIMER_WIDTH  8'h10

// converter_control_reg fields
`define CTRL_MODE_LSB     0
`define CTRL_MODE_MSB     2
`define CTRL_TRACK_BIT    3
`define CTRL_BUSY_BIT     4
`define CTRL_DONE_BIT     5
`define CTRL_IE_BIT       6
`define CTRL_RESET        8'h00

// converter_config_reg fields
`define CFG_EIGHT_BIT     0
`define CFG_JUSTIFY_BIT   2
`define CFG_DIV_LSB       3
`define CFG_DIV_MSB       7
`define CFG_RESET         8'hF8

// timer width register fields
`define TW_TIMER2_WIDE    0
`define TW_TIMER3_WIDE    1
`define TW_RESET          8'h00

// start-mode codes
`define MODE_SOFTWARE     3'h0
`define MODE_TIMER0       3'h1
`define MODE_TIMER2       3'h2
`define MODE_TIMER1       3'h3
`define MODE_PIN          3'h4
`define MODE_TIMER3       3'h5

// timing
`define CLK_HZ            20000000
`define MAX_RATE_SPS      500000
`define MIN_CONV_CYCLES   (`CLK_HZ / `MAX_RATE_SPS)
`define DELAY_TICKS       3
`define BITS_FULL         10
`define BITS_SHORT        8

`endif

// ### rtl/sar_adc_control.v
/*
 * Conversion control around a 10-bit successive-approximation converter:
 * AHB-Lite register slave, start-source selection, converter clock divider,
 * tracking window, bit-by-bit approximation and result formatting.
 * Assumes the analog comparator and the external start pin are
 * asynchronous, and the timer overflow pulses come from clk_sys logic.
 */
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_defines.vh"

module sar_adc_control #(
    parameter MIN_CONV = `MIN_CONV_CYCLES
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // start sources
    input  wire        timer0Overflow,
    input  wire        timer1Overflow,
    input  wire        timer2LowOverflow,
    input  wire        timer2HighOverflow,
    input  wire        timer3LowOverflow,
    input  wire        timer3HighOverflow,
    input  wire        externalStartPin,
    // analog front end
    input  wire        comparatorHigh,
    output reg  [9:0]  dacCode,
    output reg         trackEnable,
    output reg         sarClock,
    // status
    output reg         conversionBusy,
    output reg         conversionIrq
);

////////////////////////////////////////////////////////////////////////////////
// state codes and helpers

localparam ST_IDLE  = 2'h0;
localparam ST_DELAY = 2'h1;
localparam ST_CONV  = 2'h2;

localparam integer MIN_CONV_I  = MIN_CONV - 1;
localparam [7:0]   MIN_CONV_M1 = MIN_CONV_I[7:0];

// byte pair for a finished code under the current format settings
function [15:0] formatResult;
    input [9:0] code;
    input       eightBit;
    input       leftJust;
    begin
        if (eightBit) begin
            formatResult = {code[9:2], 8'h00};
        end else if (leftJust) begin
            formatResult = {code, 6'h00};
        end else begin
            formatResult = {6'h00, code};
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg  [2:0] startMode_reg;
reg        trackMode_reg;
reg        doneFlag_reg;
reg        doneIe_reg;
reg        eightBit_reg;
reg        justify_reg;
reg  [4:0] clockDiv_reg;
reg        timer2Wide_reg;
reg        timer3Wide_reg;
reg  [7:0] resultHigh_reg;
reg  [7:0] resultLow_reg;

reg  [1:0] state_reg;
reg  [4:0] divCount_reg;
reg  [1:0] delayCount_reg;
reg  [3:0] bitIndex_reg;
reg  [7:0] rateCount_reg;

// AHB address-phase capture
reg        wrPending_reg;
reg  [7:0] wrAddr_reg;

// synchronisers: the first stage feeds only the second
reg  [2:0] pinSync_reg;
reg        pinLevel_reg;
reg  [2:0] cmpSync_reg;
reg        cmpLevel_reg;

////////////////////////////////////////////////////////////////////////////////
// bus decode

wire       addrPhase  = hsel & htrans[1] & hready;
wire       busWrite   = wrPending_reg;
wire [7:0] wdByte     = hwdata[7:0];
wire       wrControl  = busWrite & (wrAddr_reg == `ADDR_CONTROL);
wire       wrConfig   = busWrite & (wrAddr_reg == `ADDR_CONFIG);
wire       wrTimerW   = busWrite & (wrAddr_reg == `ADDR_TIMER_WIDTH);

wire [7:0] controlView = {1'b0, doneIe_reg, doneFlag_reg,
                          (state_reg != ST_IDLE), trackMode_reg,
                          startMode_reg};
wire [7:0] configView  = {clockDiv_reg, justify_reg, 1'b0, eightBit_reg};

reg  [7:0] readByte;
always @* begin
    case (haddr)
        `ADDR_CONTROL:     readByte = controlView;
        `ADDR_CONFIG:      readByte = configView;
        `ADDR_RESULT_HIGH: readByte = resultHigh_reg;
        `ADDR_RESULT_LOW:  readByte = resultLow_reg;
        `ADDR_TIMER_WIDTH: readByte = {6'h00, timer3Wide_reg, timer2Wide_reg};
        default:           readByte = 8'h00;
    endcase
end

always @(posedge clk_sys) begin
    if (reset) begin
        hrdata        <= 32'h00000000;
        hreadyout     <= 1'b1;
        hresp         <= 1'b0;
        wrPending_reg <= 1'b0;
        wrAddr_reg    <= 8'h00;
    end else begin
        hreadyout     <= 1'b1;
        hresp         <= 1'b0;
        wrPending_reg <= addrPhase & hwrite;
        wrAddr_reg    <= haddr;
        if (addrPhase & ~hwrite) begin
            hrdata <= {24'h000000, readByte};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// input synchronisers: a change counts once stages two and three agree

always @(posedge clk_sys) begin
    if (reset) begin
        pinSync_reg  <= 3'h0;
        pinLevel_reg <= 1'b0;
        cmpSync_reg  <= 3'h0;
        cmpLevel_reg <= 1'b0;
    end else begin
        pinSync_reg <= {pinSync_reg[1:0], externalStartPin};
        cmpSync_reg <= {cmpSync_reg[1:0], comparatorHigh};
        if (pinSync_reg[1] == pinSync_reg[2]) begin
            pinLevel_reg <= pinSync_reg[2];
        end
        if (cmpSync_reg[1] == cmpSync_reg[2]) begin
            cmpLevel_reg <= cmpSync_reg[2];
        end
    end
end

wire pinRise = (pinSync_reg[1] == pinSync_reg[2]) & pinSync_reg[2]
               & ~pinLevel_reg;

////////////////////////////////////////////////////////////////////////////////
// start source selection

wire swStart = wrControl & wdByte[`CTRL_BUSY_BIT];
// timer 2/3 use the byte overflow that matches their width
wire t2Event = timer2Wide_reg ? timer2HighOverflow
                              : timer2LowOverflow;
wire t3Event = timer3Wide_reg ? timer3HighOverflow
                              : timer3LowOverflow;

reg startEvent;
always @* begin
    case (startMode_reg)
        `MODE_SOFTWARE: startEvent = swStart;
        `MODE_TIMER0:   startEvent = timer0Overflow;
        `MODE_TIMER2:   startEvent = t2Event;
        `MODE_TIMER1:   startEvent = timer1Overflow;
        `MODE_PIN:      startEvent = pinRise;
        `MODE_TIMER3:   startEvent = t3Event;
        default:        startEvent = 1'b0;
    endcase
end

// starts inside the rate window or during a conversion are dropped
wire startTaken = startEvent & (state_reg == ST_IDLE)
                  & (rateCount_reg == 8'h00);

////////////////////////////////////////////////////////////////////////////////
// converter clock: restarted at each start so bit timing is repeatable

wire sarTick = (divCount_reg == clockDiv_reg);

always @(posedge clk_sys) begin
    if (reset) begin
        divCount_reg <= 5'h00;
        sarClock     <= 1'b0;
    end else begin
        if (startTaken | sarTick) begin
            divCount_reg <= 5'h00;
        end else begin
            divCount_reg <= divCount_reg + 5'h01;
        end
        sarClock <= (divCount_reg < {1'b0, clockDiv_reg[4:1]});
    end
end

////////////////////////////////////////////////////////////////////////////////
// conversion sequencer

wire [3:0] lastIndex = eightBit_reg ? 4'h2 : 4'h0;
wire       finishing = (state_reg == ST_CONV) & sarTick
                       & (bitIndex_reg == lastIndex);
wire [9:0] finalCode = cmpLevel_reg ? dacCode
                     : (dacCode & ~(10'h001 << bitIndex_reg));

always @(posedge clk_sys) begin
    if (reset) begin
        state_reg      <= ST_IDLE;
        delayCount_reg <= 2'h0;
        bitIndex_reg   <= 4'h9;
        dacCode        <= 10'h000;
        rateCount_reg  <= 8'h00;
    end else begin
        if (startTaken) begin
            rateCount_reg <= MIN_CONV_M1;
        end else if (rateCount_reg != 8'h00) begin
            rateCount_reg <= rateCount_reg - 8'h01;
        end
        case (state_reg)
            ST_IDLE: begin
                if (startTaken & trackMode_reg) begin
                    state_reg      <= ST_DELAY;
                    delayCount_reg <= 2'h0;
                end else if (startTaken) begin
                    state_reg    <= ST_CONV;
                    bitIndex_reg <= 4'h9;
                    dacCode      <= 10'h200;
                end
            end
            ST_DELAY: begin
                if (sarTick & (delayCount_reg == `DELAY_TICKS - 1)) begin
                    state_reg    <= ST_CONV;
                    bitIndex_reg <= 4'h9;
                    dacCode      <= 10'h200;
                end else if (sarTick) begin
                    delayCount_reg <= delayCount_reg + 2'h1;
                end
            end
            ST_CONV: begin
                if (finishing) begin
                    state_reg <= ST_IDLE;
                    dacCode   <= finalCode;
                end else if (sarTick) begin
                    // keep or drop the trial bit, then try the next one
                    dacCode      <= finalCode
                                    | (10'h001 << (bitIndex_reg - 4'h1));
                    bitIndex_reg <= bitIndex_reg - 4'h1;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// results and flags: the result pair is written in the same edge that
// sets the done flag, so a set flag always sees fresh data

wire [15:0] resultPair = formatResult(finalCode, eightBit_reg, justify_reg);

always @(posedge clk_sys) begin
    if (reset) begin
        resultHigh_reg <= 8'h00;
        resultLow_reg  <= 8'h00;
    end else if (finishing) begin
        resultHigh_reg <= resultPair[15:8];
        resultLow_reg  <= resultPair[7:0];
    end
end

always @(posedge clk_sys) begin
    if (reset) begin
        startMode_reg  <= 3'h0;
        trackMode_reg  <= 1'b0;
        doneFlag_reg   <= 1'b0;
        doneIe_reg     <= 1'b0;
        eightBit_reg   <= 1'b0;
        justify_reg    <= 1'b0;
        clockDiv_reg   <= 5'h1F;
        timer2Wide_reg <= 1'b0;
        timer3Wide_reg <= 1'b0;
    end else begin
        if (wrControl) begin
            startMode_reg <= wdByte[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
            trackMode_reg <= wdByte[`CTRL_TRACK_BIT];
            doneIe_reg    <= wdByte[`CTRL_IE_BIT];
        end
        if (wrConfig) begin
            eightBit_reg <= wdByte[`CFG_EIGHT_BIT];
            justify_reg  <= wdByte[`CFG_JUSTIFY_BIT];
            clockDiv_reg <= wdByte[`CFG_DIV_MSB:`CFG_DIV_LSB];
        end
        if (wrTimerW) begin
            timer2Wide_reg <= wdByte[`TW_TIMER2_WIDE];
            timer3Wide_reg <= wdByte[`TW_TIMER3_WIDE];
        end
        // completion outranks a clearing write in the same cycle
        if (finishing) begin
            doneFlag_reg <= 1'b1;
        end else if (wrControl & ~wdByte[`CTRL_DONE_BIT]) begin
            doneFlag_reg <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// status outputs

reg trackNext;
always @* begin
    if (state_reg == ST_CONV) begin
        trackNext = 1'b0;
    end else if (state_reg == ST_DELAY) begin
        trackNext = 1'b1;
    end else if (startMode_reg == `MODE_PIN) begin
        trackNext = trackMode_reg | ~pinLevel_reg;
    end else begin
        trackNext = 1'b1;
    end
end

always @(posedge clk_sys) begin
    if (reset) begin
        trackEnable    <= 1'b1;
        conversionBusy <= 1'b0;
        conversionIrq  <= 1'b0;
    end else begin
        trackEnable    <= trackNext;
        conversionBusy <= (state_reg != ST_IDLE) & ~finishing
                          | startTaken;
        conversionIrq  <= (doneFlag_reg | finishing) & doneIe_reg
                          & ~(wrControl & ~wdByte[`CTRL_IE_BIT]);
    end
end

endmodule
`default_nettype wire

// ### verification/analog_front_model.sv
/*
 * Comparator model at the converter's analog side.
 * Assumes the bench sets the input level as a ten-bit code.
 */
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
    // trial code and input level
    input  wire logic [9:0] dacCode,
    input  wire logic [9:0] levelCode,
    // comparator decision
    output var  logic       comparatorHigh
);
    // high while the input is at or above the trial code
    always_comb comparatorHigh = (levelCode >= dacCode);
endmodule
`default_nettype wire

// ### verification/sar_adc_control_assertions.sv
/*
 * Port checker for the converter control block.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_assertions #(
    parameter int MIN_CONV = 40
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // converter
    input wire logic        externalStartPin,
    input wire logic [9:0]  dacCode,
    input wire logic        trackEnable,
    input wire logic        sarClock,
    input wire logic        conversionBusy,
    input wire logic        conversionIrq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // cycles since the last rise of busy, saturating
    logic [7:0] gap_reg;
    logic       busyQ_reg;
    always @(posedge clk_sys) begin
        if (reset) begin
            gap_reg   <= 8'hFF;
            busyQ_reg <= 1'b0;
        end else begin
            busyQ_reg <= conversionBusy;
            if (conversionBusy && !busyQ_reg)
                gap_reg <= 8'h01;
            else if (gap_reg != 8'hFF)
                gap_reg <= gap_reg + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    ready_always_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rdata_load_a: assert property ($changed(hrdata)
        |-> $past(hsel && htrans[1] && !hwrite && hready))
        else $error("read data moved without a read");
    reset_vals_a: assert property (disable iff (1'b0) reset |=>
        !conversionBusy && !conversionIrq && trackEnable
        && dacCode == 10'h0 && !sarClock)
        else $error("bad value after reset");
    busy_min_a: assert property ($rose(conversionBusy)
        |=> conversionBusy [*7])
        else $error("busy dropped too early");
    rate_gap_a: assert property (conversionBusy && !busyQ_reg
        |-> gap_reg >= MIN_CONV)
        else $error("starts closer than the rate limit");
    idle_track_a: assert property (!trackEnable && !conversionBusy
        && !$past(conversionBusy) |-> $past(externalStartPin, 2)
        || $past(externalStartPin, 3) || $past(externalStartPin, 4)
        || $past(externalStartPin, 5))
        else $error("idle converter not tracking");
endmodule
bind sar_adc_control sar_adc_control_assertions #(.MIN_CONV(MIN_CONV))
    u_sar_adc_control_assertions (.clk_sys(clk_sys), .reset(reset),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .externalStartPin(externalStartPin), .dacCode(dacCode),
    .trackEnable(trackEnable), .sarClock(sarClock),
    .conversionBusy(conversionBusy), .conversionIrq(conversionIrq));
`default_nettype wire

// ### verification/tb_sar_adc_control.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the comparator model and a bus master of single word transfers.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_control;
    logic        clk_sys = 1'b0, reset = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, pin = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [5:0]  tmr = 6'h00;
    logic [9:0]  level = 10'h000, dacCode;
    logic        hready, hreadyout, hresp, comparatorHigh;
    logic        trackEnable, sarClock, conversionBusy, conversionIrq;
    int          num_errors = 0, num_checks = 0, cyc = 0;
    int          busyRun = 0, busyLen = 0, trkRun = 0, trkLen = 0;
    int          len10, trk0;
    assign hready = hreadyout;
    always #25 clk_sys = ~clk_sys;
    sar_adc_control u_sar_adc_control (.clk_sys(clk_sys), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .timer0Overflow(tmr[0]),
        .timer1Overflow(tmr[1]), .timer2LowOverflow(tmr[2]),
        .timer2HighOverflow(tmr[3]), .timer3LowOverflow(tmr[4]),
        .timer3HighOverflow(tmr[5]), .externalStartPin(pin),
        .comparatorHigh(comparatorHigh), .dacCode(dacCode),
        .trackEnable(trackEnable), .sarClock(sarClock),
        .conversionBusy(conversionBusy), .conversionIrq(conversionIrq));
    analog_front_model u_analog_front_model (.dacCode(dacCode),
        .levelCode(level), .comparatorHigh(comparatorHigh));
    ////////////////////////////////////////////////////////////////////////
    // busy length and tracked cycles inside busy, latched at busy end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (conversionBusy) begin
            busyRun <= busyRun + 1;
            trkRun <= trkRun + trackEnable;
        end else if (busyRun != 0) begin
            busyLen <= busyRun;
            trkLen <= trkRun;
            busyRun <= 0;
            trkRun <= 0;
        end
        if (cyc == 20000) begin
            num_errors++;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task addr(input logic [7:0] a, input logic w);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        addr(a, 1'b1);
        hwdata <= v;
        do @(posedge clk_sys); while (hready !== 1'b1);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        addr(a, 1'b0);
        do @(posedge clk_sys); while (hready !== 1'b1);
        v = hrdata;
    endtask
    task wait_done;
        logic [31:0] d;
        int n;
        n = 0;
        repeat (2) @(posedge clk_sys);
        while (conversionBusy !== 1'b0 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 3000) begin
            num_errors++;
        end
        repeat (2) @(posedge clk_sys);
        rd(8'h00, d);
        chk1(d[5], 1'b1);
    endtask
    task conv(input logic [7:0] cfg, ctl, input logic [9:0] lv);
        level <= lv;
        wr(8'h04, {24'h0, cfg});
        // mode and tracking settle before the start write uses them
        wr(8'h00, {24'h0, ctl});
        wr(8'h00, {24'h0, ctl | 8'h10});
        wait_done;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0]  ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
        logic [31:0] ex [6] = '{32'h0, 32'hF8, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] d;
        wr(8'h08, 32'hFF);
        wr(8'h14, 32'hFF);
        for (int i = 0; i < 6; i++) begin
            rd(ad[i], d);
            chk(d, ex[i]);
        end
    endtask
    task automatic t_fmt;
        logic [9:0]  lv [4] = '{10'h3FF, 10'h200, 10'h155, 10'h000};
        logic [15:0] e;
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 2; j++) begin
                conv({5'h04, j[0], 2'h0}, 8'h00, lv[i]);
                e = j ? {lv[i], 6'h00} : {6'h00, lv[i]};
                rd(8'h08, d);
                chk(d, {24'h0, e[15:8]});
                rd(8'h0C, d);
                chk(d, {24'h0, e[7:0]});
            end
        end
        chk1(trackEnable, 1'b1);
        len10 = busyLen;
        trk0 = trkLen;
        for (int j = 0; j < 2; j++) begin
            conv({5'h04, j[0], 2'h1}, 8'h40, 10'h2A7);
            rd(8'h08, d);
            chk(d, 32'hA9);
            rd(8'h0C, d);
            chk(d, 32'h0);
        end
        chk1(conversionIrq, 1'b1);
        chk(len10 - busyLen, 32'hA);
        wr(8'h00, 32'h40);
        repeat (3) @(posedge clk_sys);
        chk1(conversionIrq, 1'b0);
    endtask
    task t_done;
        logic [31:0] d;
        conv(8'h20, 8'h00, 10'h123);
        wr(8'h00, 32'h30);
        rd(8'h00, d);
        chk(d, 32'h30);
        rd(8'h0C, d);
        chk(d, 32'h23);
        wait_done;
        conv(8'h20, 8'h08, 10'h0AA);
        chk(trkLen - trk0, 32'hF);
    endtask
    task automatic t_src;
        logic [2:0] md [4] = '{3'h1, 3'h3, 3'h2, 3'h5};
        int k;
        for (int i = 0; i < 4; i++) begin
            for (int w = 0; w < 2; w++) begin
                k = md[i] == 3'h1 ? 0 : md[i] == 3'h3 ? 1
                    : md[i] == 3'h2 ? 2 + w : 4 + w;
                wr(8'h10, w ? 32'h3 : 32'h0);
                wr(8'h00, {29'h0, md[i]});
                tmr <= ~(6'h01 << k);
                @(posedge clk_sys);
                tmr <= 6'h00;
                repeat (8) @(posedge clk_sys);
                chk1(conversionBusy, 1'b0);
                tmr <= 6'h01 << k;
                @(posedge clk_sys);
                tmr <= 6'h00;
                wait_done;
            end
        end
    endtask
    task t_pin;
        wr(8'h00, 32'h04);
        repeat (8) @(posedge clk_sys);
        chk1(trackEnable, 1'b1);
        // the pin feeds the start input and, with track mode off, holds tracking off while high
        pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wait_done;
        repeat (8) @(posedge clk_sys);
        chk1(trackEnable, 1'b0);
        wr(8'h00, 32'h0C);
        repeat (8) @(posedge clk_sys);
        chk1(trackEnable, 1'b1);
        pin <= 1'b0;
    endtask
    task t_rate;
        conv(8'h00, 8'h00, 10'h000);
        wr(8'h00, 32'h10);
        repeat (3) @(posedge clk_sys);
        chk1(conversionBusy, 1'b0);
        repeat (40) @(posedge clk_sys);
        wr(8'h00, 32'h10);
        repeat (2) @(posedge clk_sys);
        chk1(conversionBusy, 1'b1);
        wait_done;
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs;
        t_fmt;
        t_done;
        t_src;
        t_pin;
        t_rate;
        wrap_up;
    end
endmodule
`default_nettype wire
